// ### rtl/sie_defines.svh
// Offsets, field positions, opcodes and sizes of the interrupt/error controller
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH
`define OP_CLEAR_ERR      8'h24
`define OP_INT_ENABLE     8'h19
`define OP_INT_DISABLE    8'h1a
`define OP_VECTOR_DEFINE  8'h25
`define OP_HANDLER_RETURN 8'h26
`define INT_GLOBAL        8'hff
`define STATUS_OK         8'h64
`define NUM_ERR_FLAGS     5
`define NUM_INTS          8
`define VEC_AW            3
// Register byte offsets
`define REG_CMD_HI        12'h000
`define REG_CMD_LO        12'h004
`define REG_CMD_GO        12'h008
`define REG_REPLY         12'h00c
`define REG_ERR_FLAGS     12'h010
`define REG_INT_STATE     12'h014
`define REG_PC            12'h018
`define REG_ACCU          12'h01c
`define REG_XREG          12'h020
`define REG_IRQ_STATUS    12'h024
`define REG_IRQ_CLEAR     12'h028
`define REG_IRQ_ENABLE    12'h02c
`define REG_VEC_BASE      12'h040
// Command-go register fields
`define GO_DIRECT_BIT     0
`define GO_SUM_LSB        8
// Interrupt status bits
`define EV_CMD_DONE       0
`define EV_HANDLER_ENTER  1
`define EV_HANDLER_RETURN 2
`define EV_BAD_SUM        3
`define NUM_EVENTS        4
`endif

// ### rtl/sie_pkg.sv
// Types shared by the interrupt/error controller
`default_nettype none
package sie_pkg;
   typedef enum logic [1:0] {
      st_idle   = 2'b00,
      st_exec   = 2'b01,
      st_reply  = 2'b10
   } exec_state_t;
   typedef struct packed {
      logic [7:0]  target;
      logic [7:0]  opcode;
      logic [7:0]  kind;
      logic [7:0]  bank;
      logic [31:0] value;
      logic [7:0]  sum;
   } frame_t;
endpackage
`default_nettype wire

// ### rtl/sie_ctx_if.sv
// Context save/restore signals between the controller and its context store
`default_nettype none
interface sie_ctx_if;
   logic        save;
   logic        restore;
   logic [31:0] cur_accu;
   logic [31:0] cur_xreg;
   logic [7:0]  cur_flags;
   logic [31:0] cur_pc;
   logic [31:0] saved_accu;
   logic [31:0] saved_xreg;
   logic [7:0]  saved_flags;
   logic [31:0] saved_pc;
   modport ctrl  (output save, restore, cur_accu, cur_xreg, cur_flags, cur_pc,
                  input saved_accu, saved_xreg, saved_flags, saved_pc);
   modport store (input save, restore, cur_accu, cur_xreg, cur_flags, cur_pc,
                  output saved_accu, saved_xreg, saved_flags, saved_pc);
endinterface
`default_nettype wire

// ### rtl/sie_ctx_store.sv
// Saved interpreter context while a handler runs
`default_nettype none
module sie_ctx_store (
   input  wire logic hclk,
   input  wire logic hresetn,
   sie_ctx_if.store  ctx
);
   // Single level: handlers do not nest, so one slot is enough
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctx.saved_accu  <= 32'h0;
         ctx.saved_xreg  <= 32'h0;
         ctx.saved_flags <= 8'h0;
         ctx.saved_pc    <= 32'h0;
      end else if (ctx.save) begin
         ctx.saved_accu  <= ctx.cur_accu;
         ctx.saved_xreg  <= ctx.cur_xreg;
         ctx.saved_flags <= ctx.cur_flags;
         ctx.saved_pc    <= ctx.cur_pc;
      end
   end
endmodule
`default_nettype wire

// ### rtl/sie_vector_table.sv
// Handler entry address table, one word per interrupt number
`default_nettype none
module sie_vector_table #(
   parameter int N  = 8,
   parameter int AW = 3
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          wr,
   input  wire logic [AW-1:0] wr_idx,
   input  wire logic [31:0]   wr_addr,
   input  wire logic [AW-1:0] rd_idx,
   output logic [31:0]        rd_addr,
   input  wire logic [AW-1:0] sw_idx,
   output logic [31:0]        sw_addr
);
   logic [31:0] table_mem [N];
   // Later definitions simply overwrite earlier ones
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < N; i++) table_mem[i] <= 32'h0;
      end else if (wr) begin
         table_mem[wr_idx] <= wr_addr;
      end
   end
   assign rd_addr = table_mem[rd_idx];
   assign sw_addr = table_mem[sw_idx];
endmodule
`default_nettype wire

// ### rtl/script_interrupt_error_ctrl.sv
// Interrupt and error-flag command executor with AHB-Lite register slave
// Behaviour
// - Opcode 36 clears error flags per type
// - Type 0 all, 1..5 single flag
// - Frame: addr, opcode, type, bank, value, sum
// - Opcode 25 enables interrupt in type
// - Enable 255 turns global processing on
// - Opcode 26 disables interrupt in type
// - Disable 255 turns global processing off
// - Opcode 37 in a stored program records value as handler entry
// - Vector redefinition overwrites older entry
// - Opcode 38 in a stored program restores context except error flags, resumes program
// - Direct mode replies status 100
`default_nettype none
`include "sie_defines.svh"
module script_interrupt_error_ctrl
   import sie_pkg::*;
#(
   parameter int NUM_INTS = `NUM_INTS
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [11:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   input  wire logic [`NUM_ERR_FLAGS-1:0]  err_events,
   input  wire logic [NUM_INTS-1:0]        int_requests,
   output logic [`NUM_ERR_FLAGS-1:0]       err_flags,
   output logic                            in_handler,
   output logic [31:0]                     prog_counter,
   output logic                            irq
);
   localparam int AW = `VEC_AW;

   // Bus address phase capture
   logic        wr_pend;
   logic [11:0] addr_q;
   wire         addr_ok = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         addr_q  <= 12'h0;
      end else begin
         wr_pend <= addr_ok && hwrite;
         if (addr_ok) addr_q <= haddr;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   wire wr_cmd_hi   = wr_pend && hit(addr_q, `REG_CMD_HI);
   wire wr_cmd_lo   = wr_pend && hit(addr_q, `REG_CMD_LO);
   wire wr_cmd_go   = wr_pend && hit(addr_q, `REG_CMD_GO);
   wire wr_irq_clr  = wr_pend && hit(addr_q, `REG_IRQ_CLEAR);
   wire wr_irq_en   = wr_pend && hit(addr_q, `REG_IRQ_ENABLE);
   wire wr_pc       = wr_pend && hit(addr_q, `REG_PC);
   wire wr_accu     = wr_pend && hit(addr_q, `REG_ACCU);
   wire wr_xreg     = wr_pend && hit(addr_q, `REG_XREG);

   // Command frame staging: hi = addr/opcode/type/bank, lo = value
   logic [31:0] cmd_hi;
   logic [31:0] cmd_lo;
   logic [7:0]  cmd_sum;
   logic        cmd_direct;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_hi     <= 32'h0;
         cmd_lo     <= 32'h0;
         cmd_sum    <= 8'h0;
         cmd_direct <= 1'b0;
      end else begin
         if (wr_cmd_hi) cmd_hi <= hwdata;
         if (wr_cmd_lo) cmd_lo <= hwdata;
         if (wr_cmd_go) begin
            cmd_sum    <= hwdata[`GO_SUM_LSB +: 8];
            cmd_direct <= hwdata[`GO_DIRECT_BIT];
         end
      end
   end

   // Frame fields in wire order, value most significant byte first
   frame_t frame;
   assign frame = {cmd_hi, cmd_lo, cmd_sum};

   // Checksum is the byte sum of the eight leading bytes
   wire [7:0] calc_sum = 8'(frame.target + frame.opcode + frame.kind + frame.bank +
                            frame.value[31:24] + frame.value[23:16] +
                            frame.value[15:8] + frame.value[7:0]);
   wire       sum_ok = (calc_sum == frame.sum);

   // Executor
   exec_state_t state;
   exec_state_t next_state;
   logic        go_q;
   logic        exec_now;
   always_comb begin
      next_state = state;
      unique case (state)
         st_idle:  if (go_q) next_state = st_exec;
         st_exec:  next_state = cmd_direct ? st_reply : st_idle;
         st_reply: next_state = st_idle;
      endcase
   end
   assign exec_now = (state == st_exec) && sum_ok;
   wire   bad_sum  = (state == st_exec) && !sum_ok;

   wire is_clear  = exec_now && frame.opcode == `OP_CLEAR_ERR;
   wire is_en     = exec_now && frame.opcode == `OP_INT_ENABLE;
   wire is_dis    = exec_now && frame.opcode == `OP_INT_DISABLE;
   // Vector and return are only honoured from stored programs
   wire is_vector_define_cmd   = exec_now && !cmd_direct && frame.opcode == `OP_VECTOR_DEFINE;
   wire is_ret    = exec_now && !cmd_direct && frame.opcode == `OP_HANDLER_RETURN;
   wire is_global = (frame.kind == `INT_GLOBAL);
   wire [AW-1:0] int_idx = frame.kind[AW-1:0];
   wire          idx_ok  = (frame.kind < 8'(NUM_INTS));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= st_idle;
         go_q  <= 1'b0;
      end else begin
         state <= next_state;
         go_q  <= wr_cmd_go && (state == st_idle);
      end
   end

   // Direct-mode reply: status 100, value carries nothing
   logic [15:0] reply;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) reply <= 16'h0;
      else if (state == st_exec && cmd_direct) reply <= {frame.opcode, `STATUS_OK};
   end

   // Error flags: set by events, cleared by command; set wins
   logic [`NUM_ERR_FLAGS-1:0] clr_mask;
   always_comb begin
      clr_mask = '0;
      if (is_clear) begin
         if (frame.kind == 8'h00) clr_mask = '1;
         else if (frame.kind <= 8'(`NUM_ERR_FLAGS))
            clr_mask[3'(frame.kind - 8'h01)] = 1'b1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) err_flags <= '0;
      else err_flags <= (err_flags & ~clr_mask) | err_events;
   end

   // Interrupt enables and global switch
   logic [NUM_INTS-1:0] int_en;
   logic                global_en;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_en    <= '0;
         global_en <= 1'b0;
      end else begin
         if (is_en && is_global) global_en <= 1'b1;
         if (is_dis && is_global) global_en <= 1'b0;
         if (is_en && !is_global && idx_ok) int_en[int_idx] <= 1'b1;
         if (is_dis && !is_global && idx_ok) int_en[int_idx] <= 1'b0;
      end
   end

   // Pending interrupt requests, sticky until taken
   logic [NUM_INTS-1:0] int_pend;
   logic [NUM_INTS-1:0] take_mask;
   logic [AW-1:0]       take_idx;
   logic                take_any;
   always_comb begin
      take_idx = '0;
      take_any = 1'b0;
      for (int i = NUM_INTS - 1; i >= 0; i--) begin
         if (int_pend[i] && int_en[i]) begin
            take_idx = AW'(i);
            take_any = 1'b1;
         end
      end
   end
   // Only between commands, so a handler never splits one
   wire take = take_any && global_en && !in_handler && (state == st_idle) && !go_q;
   always_comb begin
      take_mask = '0;
      if (take) take_mask[take_idx] = 1'b1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) int_pend <= '0;
      else int_pend <= (int_pend & ~take_mask) | int_requests;
   end

   // Vector table and context store
   logic [31:0] vec_addr;
   logic [31:0] vec_sw;
   sie_vector_table #(.N(NUM_INTS), .AW(AW)) u_vec (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (is_vector_define_cmd && idx_ok),
      .wr_idx  (int_idx),
      .wr_addr (frame.value),
      .rd_idx  (take_idx),
      .rd_addr (vec_addr),
      .sw_idx  (haddr[AW+1:2]),
      .sw_addr (vec_sw)
   );

   sie_ctx_if ctx ();
   logic [31:0] accu;
   logic [31:0] xreg;
   logic [7:0]  flags_word;
   assign flags_word = {3'h0, err_flags};
   assign ctx.save      = take;
   assign ctx.restore   = is_ret && in_handler;
   assign ctx.cur_accu  = accu;
   assign ctx.cur_xreg  = xreg;
   assign ctx.cur_flags = flags_word;
   assign ctx.cur_pc    = prog_counter;
   sie_ctx_store u_ctx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ctx     (ctx)
   );

   // Interpreter context; software runs the program and writes these
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         accu         <= 32'h0;
         xreg         <= 32'h0;
         prog_counter <= 32'h0;
         in_handler   <= 1'b0;
      end else if (take) begin
         prog_counter <= vec_addr;
         in_handler   <= 1'b1;
      end else if (ctx.restore) begin
         accu         <= ctx.saved_accu;
         xreg         <= ctx.saved_xreg;
         prog_counter <= ctx.saved_pc;
         in_handler   <= 1'b0;
      end else begin
         if (wr_accu) accu <= hwdata;
         if (wr_xreg) xreg <= hwdata;
         if (wr_pc) prog_counter <= hwdata;
      end
   end
   // Saved flags are never written back into the error flags on return;
   // live events must never be lost to a stale copy.

   // Event status, write-one-to-clear, set wins
   logic [`NUM_EVENTS-1:0] ev_status;
   logic [`NUM_EVENTS-1:0] ev_enable;
   logic [`NUM_EVENTS-1:0] ev_set;
   assign ev_set = {bad_sum, ctx.restore, take, exec_now};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_status <= '0;
         ev_enable <= '0;
      end else begin
         ev_status <= (ev_status & ~(wr_irq_clr ? hwdata[`NUM_EVENTS-1:0] : '0)) | ev_set;
         if (wr_irq_en) ev_enable <= hwdata[`NUM_EVENTS-1:0];
      end
   end
   assign irq = |(ev_status & ev_enable);

   // Read mux on the live address, so hrdata is ready for the data phase;
   // a read pipelined behind a write to the same word sees the old value
   wire vec_hit = (haddr >= `REG_VEC_BASE) &&
                  (haddr < 12'(`REG_VEC_BASE + 4 * NUM_INTS));
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0;
      if (vec_hit) rd_word = vec_sw;
      else begin
         unique case (haddr)
            `REG_CMD_HI:     rd_word = cmd_hi;
            `REG_CMD_LO:     rd_word = cmd_lo;
            `REG_CMD_GO:     rd_word = {16'h0, cmd_sum, 6'h0, state != st_idle, cmd_direct};
            `REG_REPLY:      rd_word = {16'h0, reply};
            `REG_ERR_FLAGS:  rd_word = {27'h0, err_flags};
            `REG_INT_STATE:  rd_word = {14'h0, in_handler, global_en,
                                        8'(int_pend), 8'(int_en)};
            `REG_PC:         rd_word = prog_counter;
            `REG_ACCU:       rd_word = accu;
            `REG_XREG:       rd_word = xreg;
            `REG_IRQ_STATUS: rd_word = {28'h0, ev_status};
            `REG_IRQ_ENABLE: rd_word = {28'h0, ev_enable};
            default:         rd_word = 32'h0;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0;
      else if (addr_ok && !hwrite) hrdata <= rd_word;
   end
endmodule
`default_nettype wire

// ### test/sie_ctrl_asserts.sv
// Port-level assertion checker for the interrupt and error-flag controller
`default_nettype none
`include "sie_defines.svh"
module sie_ctrl_asserts #(
   parameter int NUM_INTS = 8
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [11:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic                      hready,
   input  wire logic                      hreadyout,
   input  wire logic                      hresp,
   input  wire logic [`NUM_ERR_FLAGS-1:0] err_events,
   input  wire logic [`NUM_ERR_FLAGS-1:0] err_flags,
   input  wire logic                      in_handler,
   input  wire logic [31:0]               prog_counter,
   input  wire logic                      irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] wr_age;
   logic       en_set;
   wire        wr_take = hsel && hready && htrans[1] && hwrite;
   // Cycles since the last bus write; commands can only act shortly after one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_age <= 4'hf;
         en_set <= 1'b0;
      end else begin
         wr_age <= wr_take ? 4'h0 : (wr_age == 4'hf ? wr_age : wr_age + 4'h1);
         en_set <= en_set | (wr_take && haddr == `REG_IRQ_ENABLE);
      end
   end
   // Handler entry seen as a rising level
   sequence s_entry;
      !in_handler ##1 in_handler;
   endsequence
   ready_always_a: assert property (hreadyout)
      else $error("wait state inserted");
   resp_okay_a: assert property (!hresp)
      else $error("error response seen");
   flag_set_a: assert property (|err_events |=>
      (err_flags & $past(err_events)) == $past(err_events)) else $error("flag not set");
   flag_origin_a: assert property ((err_flags & ~$past(err_flags) & ~$past(err_events)) == '0)
      else $error("flag set without event");
   flag_clear_a: assert property (|(~err_flags & $past(err_flags)) |-> wr_age <= 4'h6)
      else $error("flag cleared without command");
   return_cmd_a: assert property ($fell(in_handler) |-> wr_age <= 4'h6)
      else $error("handler left without command");
   entry_jump_a: assert property (s_entry |-> $changed(prog_counter))
      else $error("no jump on handler entry");
   irq_setup_a: assert property (irq |-> en_set)
      else $error("irq without enable write");
endmodule
`default_nettype wire

// ### test/sie_host_model.sv
// Host model issuing command frames over the register bus
`default_nettype none
`include "sie_defines.svh"
module sie_host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [11:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // One word transfer; read data taken at the edge closing the data phase
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d; // Released data never repeats the last word
      @(posedge hclk);
   endtask
   // Whole frame: target, opcode, type, bank, value, byte-sum checksum
   task automatic cmd(input logic [7:0] op, k, input logic [31:0] v, input logic dir, bad);
      logic [31:0] q;
      logic [7:0]  sum;
      sum = 8'h01 + op + k + v[31:24] + v[23:16] + v[15:8] + v[7:0] + {7'h0, bad};
      xfer(1'b1, `REG_CMD_HI, {8'h01, op, k, 8'h00}, q);
      xfer(1'b1, `REG_CMD_LO, v, q);
      xfer(1'b1, `REG_CMD_GO, {16'h0, sum, 7'h0, dir}, q);
      repeat (4) @(posedge hclk); // Spacing before the next go
   endtask
endmodule
`default_nettype wire

// ### test/script_interrupt_error_ctrl_tb_top.sv
// Self-checking bench for the interrupt and error-flag controller
`default_nettype none
`include "sie_defines.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module script_interrupt_error_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, in_handler, irq;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, prog_counter, q;
   logic [4:0]  err_events, err_flags, e;
   logic [7:0]  int_requests;
   int          fails, checks_done, cyc;

   sie_host_model i_sie_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));
   script_interrupt_error_ctrl #(.NUM_INTS(8)) i_script_interrupt_error_ctrl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_events(err_events),
      .int_requests(int_requests), .err_flags(err_flags), .in_handler(in_handler),
      .prog_counter(prog_counter), .irq(irq));

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_sie_host_model.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a);
      i_sie_host_model.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic cmd(input logic [7:0] op, k, input logic [31:0] v, input logic dir, bad);
      i_sie_host_model.cmd(op, k, v, dir, bad);
   endtask
   task automatic set_all_flags();
      err_events <= 5'h1f;
      @(posedge hclk);
      err_events <= 5'h00;
      @(posedge hclk);
   endtask

   // Every clear type, an unused type, and a corrupted checksum
   task automatic t_clear();
      for (int k = 0; k <= 6; k++) begin
         set_all_flags();
         cmd(`OP_CLEAR_ERR, 8'(k), 32'h1234_5678, 1'b1, 1'b0);
         e = (k == 0) ? 5'h00 : 5'h1f;
         if (k >= 1 && k <= 5) e[k-1] = 1'b0;
         `CHK("flags", e, err_flags)
         rd(`REG_REPLY);
         `CHK("reply", {16'h0, `OP_CLEAR_ERR, `STATUS_OK}, q)
      end
      cmd(`OP_CLEAR_ERR, 8'h00, 32'h0, 1'b1, 1'b1);
      `CHK("flags bad sum", 5'h1f, err_flags)
      rd(`REG_IRQ_STATUS);
      `CHK("irq status", 32'h0000_0009, q)
      $display("test clear done");
   endtask

   // Define, redefine, then a direct define that must be ignored
   task automatic t_vector();
      cmd(`OP_VECTOR_DEFINE, 8'h02, 32'h0000_0050, 1'b0, 1'b0);
      cmd(`OP_VECTOR_DEFINE, 8'h02, 32'h0000_0077, 1'b0, 1'b0);
      cmd(`OP_VECTOR_DEFINE, 8'h02, 32'h0000_0099, 1'b1, 1'b0);
      rd(`REG_VEC_BASE + 12'h008);
      `CHK("vector", 32'h0000_0077, q)
      rd(`REG_REPLY);
      `CHK("reply", {16'h0, `OP_VECTOR_DEFINE, `STATUS_OK}, q)
      $display("test vector done");
   endtask

   // Enable, take the interrupt, clobber context, return
   task automatic t_handler();
      cmd(`OP_INT_ENABLE, 8'h02, 32'h0, 1'b0, 1'b0);
      cmd(`OP_INT_ENABLE, `INT_GLOBAL, 32'h0, 1'b0, 1'b0);
      rd(`REG_INT_STATE);
      `CHK("int state", 32'h0001_0004, q)
      wr(`REG_IRQ_ENABLE, 32'h2);
      wr(`REG_PC, 32'h10);
      wr(`REG_ACCU, 32'haa);
      wr(`REG_XREG, 32'hbb);
      int_requests <= 8'h04;
      @(posedge hclk);
      int_requests <= 8'h00;
      for (int i = 0; i < 20 && in_handler !== 1'b1; i++) @(posedge hclk);
      `CHK("in handler", 1'b1, in_handler)
      `CHK("pc entry", 32'h77, prog_counter)
      `CHK("irq", 1'b1, irq)
      wr(`REG_ACCU, 32'h11);
      wr(`REG_XREG, 32'h22);
      cmd(`OP_HANDLER_RETURN, 8'hff, 32'h0, 1'b0, 1'b0);
      `CHK("in handler", 1'b0, in_handler)
      `CHK("pc back", 32'h10, prog_counter)
      rd(`REG_ACCU);
      `CHK("accu", 32'haa, q)
      rd(`REG_XREG);
      `CHK("xreg", 32'hbb, q)
      rd(`REG_IRQ_STATUS);
      `CHK("irq status", 32'h0000_000f, q)
      wr(`REG_IRQ_CLEAR, 32'hf);
      `CHK("irq cleared", 1'b0, irq)
      rd(`REG_IRQ_STATUS);
      `CHK("irq status clr", 32'h0, q)
      $display("test handler done");
   endtask

   // Single and global disable; a request with global off is not taken
   task automatic t_disable();
      cmd(`OP_INT_DISABLE, 8'h02, 32'h0, 1'b1, 1'b0);
      rd(`REG_INT_STATE);
      `CHK("int state", 32'h0001_0000, q)
      cmd(`OP_INT_DISABLE, `INT_GLOBAL, 32'h0, 1'b1, 1'b0);
      rd(`REG_INT_STATE);
      `CHK("int state", 32'h0000_0000, q)
      cmd(`OP_INT_ENABLE, 8'h03, 32'h0, 1'b1, 1'b0);
      int_requests <= 8'h08;
      @(posedge hclk);
      int_requests <= 8'h00;
      repeat (8) @(posedge hclk);
      `CHK("in handler", 1'b0, in_handler)
      rd(12'h0f0);
      `CHK("unmapped", 32'h0, q)
      $display("test disable done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Free-running 125 MHz clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // Reset, then the scenarios in order
   initial begin
      hresetn = 1'b0;
      err_events = 5'h00;
      int_requests = 8'h00;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_clear();
      t_vector();
      t_handler();
      t_disable();
      report_and_stop();
   end
   // Hang guard, far above the few hundred cycles the scenarios need
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
endmodule

bind script_interrupt_error_ctrl sie_ctrl_asserts #(.NUM_INTS(NUM_INTS)) i_sie_ctrl_asserts (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .err_events(err_events), .err_flags(err_flags), .in_handler(in_handler),
   .prog_counter(prog_counter), .irq(irq));
`default_nettype wire
